// ### logic/dtc_top.v
// Behaviour
// - Timer A clock field picks count source
// - Timer B same codes, 111 is pin
// - Timer A modes: divider, PWM; cascade is set by B mode 1xx
// - Timer B mode decode incl 16-bit modes
// - Run 1 counts, 0 stops and clears
// - Stop write keeps fields; start honours
// - 16-bit: A clock, B run/preset
// - B mode 1xx counts A overflow
// - Match raises interrupt, clears, continues
// Purpose: dual 8-bit timer control, cascadable to 16 bits
// Assumes: AXI4-Lite slave, one clock, synchronous low reset
// Notes: counting shown for timer, divider and PWM style outputs
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dtc_regs.vh"
module dtc_top #(
  parameter DIV_W = `DTC_DIV_W
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Low frequency clock enable and pin event
  input wire low_freq_tick,
  input wire timer_b_pin_event,
  // Write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // Write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // Write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // Read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // Read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Timer outputs
  output reg timer_a_out,
  output reg timer_b_out,
  output wire irq
);
  // =====================================================
  // Registers
  reg [7:0] timer_a_control_reg;
  reg [7:0] timer_b_control_reg;
  reg [7:0] timer_a_period_compare_reg;
  reg [7:0] timer_a_pulse_compare_reg;
  reg [7:0] timer_b_period_compare_reg;
  reg [7:0] timer_b_pulse_compare_reg;
  reg divider_tap_option_reg;
  reg [1:0] stat_reg;
  reg [1:0] ien_reg;
  reg [7:0] cnt_a_reg;
  reg [7:0] cnt_b_reg;
  reg [DIV_W-1:0] div_reg;
  reg [`DTC_FS_DIV-1:0] fs_div_reg;
  reg aw_held_reg;
  reg w_held_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  // =====================================================
  // Field views
  wire [2:0] a_ck = timer_a_control_reg[`DTC_CK_HI:`DTC_CK_LO];
  wire [2:0] b_ck = timer_b_control_reg[`DTC_CK_HI:`DTC_CK_LO];
  wire [2:0] a_mode = timer_a_control_reg[`DTC_MODE_HI:`DTC_MODE_LO];
  wire [2:0] b_mode = timer_b_control_reg[`DTC_MODE_HI:`DTC_MODE_LO];
  wire a_run_bit = timer_a_control_reg[`DTC_RUN_BIT];
  wire b_run_bit = timer_b_control_reg[`DTC_RUN_BIT];
  wire b_ff = timer_b_control_reg[`DTC_FF_BIT];
  wire a_ff = timer_a_control_reg[`DTC_FF_BIT];
  // B upper byte in 16-bit modes
  wire wide = b_mode[2];
  // Cascade run and preset from B
  wire a_run = wide ? b_run_bit : a_run_bit;
  wire a_ff_eff = wide ? b_ff : a_ff;
  // =====================================================
  // Divider taps as one-cycle enables
  wire [DIV_W-1:0] div_inc = div_reg + {{(DIV_W-1){1'b0}}, 1'b1};
  wire t_d1 = div_reg[0];
  wire t_d3 = (div_reg[2:0] == 3'h7);
  wire t_d5 = (div_reg[4:0] == 5'h1F);
  wire t_d7 = (div_reg[6:0] == 7'h7F);
  wire t_d11 = &div_reg;
  wire t_fs3 = low_freq_tick & (&fs_div_reg);
  // Free-running prescalers
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= {DIV_W{1'b0}};
      fs_div_reg <= {`DTC_FS_DIV{1'b0}};
    end else begin
      div_reg <= div_inc;
      if (low_freq_tick)
        fs_div_reg <= fs_div_reg + {{(`DTC_FS_DIV-1){1'b0}}, 1'b1};
    end
  end
  // =====================================================
  // Source selection
  wire a_tick;
  wire b_src;
  dtc_tick_sel u_sel_a (
    .sel(a_ck),
    .tap_option(divider_tap_option_reg),
    .pin_ok(1'b0),
    .t_d11(t_d11),
    .t_fs3(t_fs3),
    .t_d7(t_d7),
    .t_d5(t_d5),
    .t_d3(t_d3),
    .t_fs(low_freq_tick),
    .t_d1(t_d1),
    .t_fc(1'b1),
    .t_pin(1'b0),
    .tick(a_tick)
  );
  // Timer B clock decode with pin
  dtc_tick_sel u_sel_b (
    .sel(b_ck),
    .tap_option(divider_tap_option_reg),
    .pin_ok(1'b1),
    .t_d11(t_d11),
    .t_fs3(t_fs3),
    .t_d7(t_d7),
    .t_d5(t_d5),
    .t_d3(t_d3),
    .t_fs(low_freq_tick),
    .t_d1(t_d1),
    .t_fc(1'b1),
    .t_pin(timer_b_pin_event),
    .tick(b_src)
  );
  // =====================================================
  // Counters
  wire a_match = (cnt_a_reg == (wide ? 8'hFF : timer_a_period_compare_reg));
  wire a_step = a_run & a_tick;
  wire a_ovf = a_step & a_match;
  wire b_tick = wide ? a_ovf : b_src;
  wire b_step = b_run_bit & b_tick;
  wire b_match = (cnt_b_reg == timer_b_period_compare_reg);
  // 16-bit match on both bytes, checked on every low-byte step
  wire a_hit = (cnt_a_reg == timer_a_period_compare_reg);
  wire ev16 = wide & a_step & a_hit & b_match;
  wire b_ev = wide ? ev16 : (b_step & b_match);
  wire a_ev = wide ? 1'b0 : a_ovf;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_a_reg <= 8'h00;
      timer_a_out <= 1'b0;
    end else if (!a_run) begin
      cnt_a_reg <= 8'h00;
      timer_a_out <= a_ff_eff;
    end else if (a_step) begin
      if (a_match || ev16)
        cnt_a_reg <= 8'h00;
      else
        cnt_a_reg <= cnt_a_reg + 8'h01;
      case (a_mode)
        `DTC_M_PDO: if (a_match) timer_a_out <= ~timer_a_out;
        `DTC_M_PWM: begin
          if (cnt_a_reg == timer_a_pulse_compare_reg)
            timer_a_out <= ~a_ff_eff;
          else if (a_match)
            timer_a_out <= a_ff_eff;
        end
        default: timer_a_out <= timer_a_out;
      endcase
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_b_reg <= 8'h00;
      timer_b_out <= 1'b0;
    end else if (!b_run_bit) begin
      cnt_b_reg <= 8'h00;
      timer_b_out <= b_ff;
    end else if (b_step || b_ev) begin
      // 8-bit or 16-bit match clears the byte
      if (b_ev)
        cnt_b_reg <= 8'h00;
      else
        cnt_b_reg <= cnt_b_reg + 8'h01;
      case (b_mode)
        `DTC_M_PDO: if (b_match) timer_b_out <= ~timer_b_out;
        `DTC_M_PWM: begin
          if (cnt_b_reg == timer_b_pulse_compare_reg)
            timer_b_out <= ~b_ff;
          else if (b_match)
            timer_b_out <= b_ff;
        end
        `DTC_M_PWM16, `DTC_M_PPG: begin
          if (cnt_b_reg == timer_b_pulse_compare_reg)
            timer_b_out <= ~b_ff;
          else if (b_ev)
            timer_b_out <= b_ff;
        end
        `DTC_M_WARM, `DTC_M_T16: if (b_ev) timer_b_out <= ~timer_b_out;
        default: timer_b_out <= timer_b_out;
      endcase
    end
  end
  // =====================================================
  // AXI write channel
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  wire wr_go = aw_held_reg && w_held_reg;
  wire [31:0] wd = w_data_reg;
  wire wlane = w_strb_reg[0];
  wire [7:0] new_ctl = wd[7:0];
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg > `DTC_CNT_OFF) ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Register writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_a_control_reg <= `DTC_CTRL_RST;
      timer_b_control_reg <= `DTC_CTRL_RST;
      timer_a_period_compare_reg <= `DTC_CMP_RST;
      timer_a_pulse_compare_reg <= `DTC_CMP_RST;
      timer_b_period_compare_reg <= `DTC_CMP_RST;
      timer_b_pulse_compare_reg <= `DTC_CMP_RST;
      divider_tap_option_reg <= 1'b0;
      ien_reg <= 2'b00;
    end else if (wr_go && wlane) begin
      case (aw_addr_reg)
        `DTC_A_CTRL_OFF: begin
          if (new_ctl[`DTC_RUN_BIT])
            timer_a_control_reg <= new_ctl;
          else
            timer_a_control_reg[`DTC_RUN_BIT] <= 1'b0;
        end
        `DTC_B_CTRL_OFF: begin
          if (new_ctl[`DTC_RUN_BIT])
            timer_b_control_reg <= new_ctl;
          else
            timer_b_control_reg[`DTC_RUN_BIT] <= 1'b0;
        end
        `DTC_A_PER_OFF: timer_a_period_compare_reg <= wd[7:0];
        `DTC_A_PUL_OFF: timer_a_pulse_compare_reg <= wd[7:0];
        `DTC_B_PER_OFF: timer_b_period_compare_reg <= wd[7:0];
        `DTC_B_PUL_OFF: timer_b_pulse_compare_reg <= wd[7:0];
        `DTC_OPT_OFF: divider_tap_option_reg <= wd[0];
        `DTC_IEN_OFF: ien_reg <= wd[1:0];
        default: ien_reg <= ien_reg;
      endcase
    end
  end
  // =====================================================
  // Interrupt status, set wins over clear
  wire clr_hit = wr_go && wlane && (aw_addr_reg == `DTC_ICLR_OFF);
  wire [1:0] clr_mask = clr_hit ? wd[1:0] : 2'b00;
  always @(posedge aclk) begin
    if (!aresetn)
      stat_reg <= 2'b00;
    else
      stat_reg <= (stat_reg & ~clr_mask) | {b_ev, a_ev};
  end
  assign irq = |(stat_reg & ien_reg);
  // =====================================================
  // AXI read channel
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `DTC_A_CTRL_OFF: s_axi_rdata <= {24'h00_0000, timer_a_control_reg};
        `DTC_B_CTRL_OFF: s_axi_rdata <= {24'h00_0000, timer_b_control_reg};
        `DTC_A_PER_OFF:
          s_axi_rdata <= {24'h00_0000, timer_a_period_compare_reg};
        `DTC_A_PUL_OFF:
          s_axi_rdata <= {24'h00_0000, timer_a_pulse_compare_reg};
        `DTC_B_PER_OFF:
          s_axi_rdata <= {24'h00_0000, timer_b_period_compare_reg};
        `DTC_B_PUL_OFF:
          s_axi_rdata <= {24'h00_0000, timer_b_pulse_compare_reg};
        `DTC_OPT_OFF: s_axi_rdata <= {31'h0, divider_tap_option_reg};
        `DTC_STAT_OFF: s_axi_rdata <= {30'h0, stat_reg};
        `DTC_IEN_OFF: s_axi_rdata <= {30'h0, ien_reg};
        `DTC_ICLR_OFF: s_axi_rdata <= 32'h0000_0000;
        `DTC_CNT_OFF: s_axi_rdata <= {16'h0000, cnt_b_reg, cnt_a_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // dtc_top

// ### logic/dtc_regs.vh
// Purpose: register map, field layout and constants of the dual timer
// Assumes: AXI4-Lite, one aligned 32-bit word per register
// Notes: definitions only
`ifndef DTC_REGS_VH
`define DTC_REGS_VH
// =====================================================
// Offsets
`define DTC_A_CTRL_OFF 8'h00
`define DTC_B_CTRL_OFF 8'h04
`define DTC_A_PER_OFF 8'h08
`define DTC_A_PUL_OFF 8'h0C
`define DTC_B_PER_OFF 8'h10
`define DTC_B_PUL_OFF 8'h14
`define DTC_OPT_OFF 8'h18
`define DTC_STAT_OFF 8'h1C
`define DTC_IEN_OFF 8'h20
`define DTC_ICLR_OFF 8'h24
`define DTC_CNT_OFF 8'h28
// =====================================================
// Control field positions
`define DTC_FF_BIT 7
`define DTC_CK_HI 6
`define DTC_CK_LO 4
`define DTC_RUN_BIT 3
`define DTC_MODE_HI 2
`define DTC_MODE_LO 0
// =====================================================
// Reset values
`define DTC_CTRL_RST 8'h00
`define DTC_CMP_RST 8'hFF
// =====================================================
// Clock select codes
`define DTC_CK_SLOW 3'h0
`define DTC_CK_D7 3'h1
`define DTC_CK_D5 3'h2
`define DTC_CK_D3 3'h3
`define DTC_CK_FS 3'h4
`define DTC_CK_D1 3'h5
`define DTC_CK_FC 3'h6
`define DTC_CK_PIN 3'h7
// =====================================================
// Mode codes
`define DTC_M_TMR 3'h0
`define DTC_M_PDO 3'h1
`define DTC_M_PWM 3'h2
`define DTC_M_CASC 3'h3
`define DTC_M_T16 3'h4
`define DTC_M_WARM 3'h5
`define DTC_M_PWM16 3'h6
`define DTC_M_PPG 3'h7
// =====================================================
// Divider taps and widths
`define DTC_DIV_W 11
`define DTC_FS_DIV 3
`endif

// ### logic/dtc_tick_sel.v
// Purpose: picks one count-enable pulse from the divider taps
// Assumes: taps are one-cycle enables on aclk
// Notes: pin events arrive already as one-cycle pulses
`timescale 1ns/1ps
module dtc_tick_sel (
  // Selection
  input wire [2:0] sel,
  input wire tap_option,
  input wire pin_ok,
  // Taps
  input wire t_d11,
  input wire t_fs3,
  input wire t_d7,
  input wire t_d5,
  input wire t_d3,
  input wire t_fs,
  input wire t_d1,
  input wire t_fc,
  input wire t_pin,
  // Result
  output reg tick
);
`include "dtc_regs.vh"
  // Clock source decode
  always @* begin
    case (sel)
      `DTC_CK_SLOW: tick = tap_option ? t_fs3 : t_d11;
      `DTC_CK_D7: tick = t_d7;
      `DTC_CK_D5: tick = t_d5;
      `DTC_CK_D3: tick = t_d3;
      `DTC_CK_FS: tick = t_fs;
      `DTC_CK_D1: tick = t_d1;
      `DTC_CK_FC: tick = t_fc;
      `DTC_CK_PIN: tick = pin_ok & t_pin;
      default: tick = 1'b0;
    endcase
  end
endmodule // dtc_tick_sel

// ### tb/dtc_top_monitor.sv
// Purpose: port checks on the dual timer block
// Assumes: one clock, aresetn synchronous active low
// Notes: attached to dtc_top by bind
`timescale 1ns/1ps
// ==========
// Port checker
module dtc_top_monitor #(
  parameter DIV_W = 11
) (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Bus handshakes
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // Outputs
  input logic timer_a_out,
  input logic timer_b_out,
  input logic irq
);
  // All checks on the one clock
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  aw_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no bvalid");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no rvalid");
  err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |->
    s_axi_rdata == 32'h0000_0000) else $error("error read not zero");
  resp_code_a: assert property (s_axi_bvalid |-> !s_axi_bresp[0])
    else $error("bad write response");
  reset_idle_a: assert property ($rose(aresetn) |-> !s_axi_bvalid &&
    !s_axi_rvalid && !irq && !timer_a_out && !timer_b_out &&
    s_axi_awready && s_axi_arready) else $error("not idle after reset");
endmodule // dtc_top_monitor

bind dtc_top dtc_top_monitor #(.DIV_W(DIV_W)) mon_u (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .timer_a_out, .timer_b_out, .irq);

// ### tb/tb_top.sv
// Purpose: self-checking bench for the dual timer block
// Assumes: AXI4-Lite master driven on rising edges
// Notes: fixed seed, random fields and periods
`timescale 1ns/1ps
`include "dtc_regs.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
// ==========
// Bench top
module tb_top;
  logic aclk = 0, aresetn = 0, low_freq_tick = 0, pin_ev = 0;
  logic [7:0] awaddr = 0, araddr = 0, v;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, ta, tb, irq;
  logic [1:0] bresp, rresp, r;
  int errors = 0, compares = 0, cyc = 0, n, dv, x;
  dtc_top #(.DIV_W(11)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .low_freq_tick(low_freq_tick), .timer_b_pin_event(pin_ev),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_a_out(ta), .timer_b_out(tb), .irq(irq));
  // Clock, low frequency enable every 16 cycles, timeout
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) begin
    low_freq_tick <= (cyc % 16 == 15);
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      test_done;
    end
  end
  // Verdict and end of run
  task test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bus write, response code left in r
  task automatic wr(input [7:0] a, input [31:0] dd, input [3:0] s = 4'h1);
    logic sa, sw, sb;
    @(posedge aclk);
    awaddr <= a; wdata <= dd; wstrb <= s;
    awvalid <= 1; wvalid <= 1; bready <= 1;
    sb = 0;
    while (!sb) begin
      @(negedge aclk);
      sa = awvalid && awready; sw = wvalid && wready;
      sb = bvalid; r = bresp;
      @(posedge aclk);
      if (sa) awvalid <= 0;
      if (sw) wvalid <= 0;
    end
    bready <= 0;
  endtask
  // Bus read, data in d and response in r
  task automatic rd(input [7:0] a);
    logic sa, sb;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    sb = 0;
    while (!sb) begin
      @(negedge aclk);
      sa = arvalid && arready; sb = rvalid; d = rdata; r = rresp;
      @(posedge aclk);
      if (sa) arvalid <= 0;
    end
    rready <= 0;
  endtask
  // One pin event pulse
  task pulse;
    @(posedge aclk) pin_ev <= 1;
    @(posedge aclk) pin_ev <= 0;
    repeat (3) @(posedge aclk);
  endtask
  // Bounded wait for interrupt, cycles in n
  task wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(negedge aclk);
      n++;
    end
  endtask
  // Cycles per count tick for a clock code
  function int exp_div(input [2:0] c, input t);
    case (c)
      0: return t ? 128 : 2048;
      1: return 128;
      2: return 32;
      3: return 8;
      4: return 16;
      5: return 2;
      default: return 1;
    endcase
  endfunction
  // Main sequence
  initial begin
    n = $urandom(32'h31e0);
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 6; i++) begin
      rd(i * 4);
      `CHK("reset", (i < 2) ? 32'h0000_0000 : 32'h0000_00ff, d);
    end
    rd(`DTC_STAT_OFF); `CHK("status", 32'h0000_0000, d);
    rd(8'h2c); `CHK("bad rd", 2'b10, r); `CHK("bad data", 32'h0, d);
    wr(8'h30, 1); `CHK("bad wr", 2'b10, r);
    // Start with fields, then stop keeps them
    for (int m = 0; m < 8; m++) begin
      v = $urandom;
      v[3] = 1; v[2:0] = m;
      if (v[6:4] == 3'h7) v[6:4] = 3'h6;
      wr(`DTC_A_CTRL_OFF, v); wr(`DTC_B_CTRL_OFF, v);
      rd(`DTC_A_CTRL_OFF); `CHK("ctl a", {24'h0, v}, d);
      rd(`DTC_B_CTRL_OFF); `CHK("ctl b", {24'h0, v}, d);
      wr(`DTC_A_CTRL_OFF, 0); wr(`DTC_B_CTRL_OFF, 0);
      rd(`DTC_A_CTRL_OFF); `CHK("stop a", {24'h0, v & 8'hf7}, d);
      rd(`DTC_CNT_OFF); `CHK("cleared", 16'h0, d[15:0]);
      `CHK("preset", v[7], ta);
    end
    wr(`DTC_A_CTRL_OFF, 8'hff, 4'he);
    rd(`DTC_A_CTRL_OFF); `CHK("strobe", {24'h0, v & 8'hf7}, d);
    // Start B once in 8-bit mode so that its stop keeps mode 000
    wr(`DTC_B_CTRL_OFF, 8'h08);
    wr(`DTC_B_CTRL_OFF, 0);
    wr(`DTC_IEN_OFF, 1);
    // Tick rate per clock code; period 2 takes three ticks
    for (int c = 0; c < 8; c++) begin
      wr(`DTC_OPT_OFF, 32'(c == 7));
      wr(`DTC_A_PER_OFF, 2);
      wr(`DTC_ICLR_OFF, 1);
      wr(`DTC_A_CTRL_OFF, {1'b0, (c == 7) ? 3'h0 : 3'(c), 4'h8});
      dv = exp_div((c == 7) ? 3'h0 : 3'(c), c == 7);
      wait_irq(7000);
      `CHK("rate lo", 1'b1, n >= 2 * dv);
      `CHK("rate hi", 1'b1, n <= 3 * dv + 4);
      rd(`DTC_STAT_OFF); `CHK("match", 1'b1, d[0]);
      wr(`DTC_A_CTRL_OFF, 0);
    end
    // Continued counting, masking and clearing
    wr(`DTC_OPT_OFF, 0);
    wr(`DTC_A_CTRL_OFF, 8'h68);
    repeat (3) begin
      rd(`DTC_CNT_OFF); `CHK("wrap", 1'b1, d[7:0] <= 2);
    end
    wr(`DTC_IEN_OFF, 0); @(negedge aclk); `CHK("masked", 1'b0, irq);
    wr(`DTC_A_CTRL_OFF, 0); wr(`DTC_IEN_OFF, 1);
    @(negedge aclk); `CHK("unmask", 1'b1, irq);
    wr(`DTC_ICLR_OFF, 1); @(negedge aclk); `CHK("clear", 1'b0, irq);
    // Timer B counts pin events
    wr(`DTC_B_PER_OFF, 3); wr(`DTC_IEN_OFF, 2);
    wr(`DTC_B_CTRL_OFF, 8'h78);
    pulse; pulse;
    rd(`DTC_CNT_OFF); `CHK("pin cnt", 8'h02, d[15:8]);
    `CHK("no match", 1'b0, irq);
    pulse; @(negedge aclk); `CHK("not yet", 1'b0, irq);
    pulse; @(negedge aclk); `CHK("pin match", 1'b1, irq);
    wr(`DTC_B_CTRL_OFF, 0); wr(`DTC_ICLR_OFF, 3);
    // Pulse compare rewritten only while stopped
    wr(`DTC_A_PUL_OFF, 8'h40);
    rd(`DTC_A_PUL_OFF); `CHK("pulse", 32'h0000_0040, d);
    // Cascade: A clock and mode 011, started from B only
    x = $urandom_range(40, 1);
    wr(`DTC_A_PER_OFF, x); wr(`DTC_B_PER_OFF, 1);
    wr(`DTC_A_CTRL_OFF, 8'h6b); wr(`DTC_A_CTRL_OFF, 0);
    wr(`DTC_ICLR_OFF, 3); wr(`DTC_IEN_OFF, 3);
    wr(`DTC_B_CTRL_OFF, 8'h0c);
    wait_irq(1000);
    `CHK("casc lo", 1'b1, n >= 252 + x);
    `CHK("casc hi", 1'b1, n <= 268 + x);
    wr(`DTC_B_CTRL_OFF, 0);
    test_done;
  end
endmodule // tb_top
